// [hw/lps_pkg.sv]
// Shared constants and types for the LIN transceiver and special mode registers
package lps_pkg;
    localparam int          WORD_W          = 16;
    localparam int          FB_W            = 12;
    typedef logic [WORD_W-1:0] lps_word_type;
    typedef logic [FB_W-1:0]   lps_fb_type;

    // Command word fields
    localparam int          SEL_HI_BIT      = 15;
    localparam int          SEL_LO_BIT      = 14;
    localparam int          FB_CHOICE_BIT   = 13;
    localparam int          NO_STORE_BIT    = 12;
    localparam logic [1:0]  SEL_LIN_CFG     = 2'h3;
    localparam logic [1:0]  SEL_SPECIAL     = 2'h1;

    // Transceiver configuration fields
    localparam int          BUS_ACTIVE_BIT  = 4;
    localparam int          SLOPE_BIT       = 3;
    localparam int          DRIVER_BIT      = 2;
    localparam int          TX_DISABLE_BIT  = 0;

    // Special mode fields
    localparam int          SW_DEV_BIT      = 9;
    localparam int          PRESC_HI_BIT    = 6;
    localparam int          PRESC_LO_BIT    = 5;

    // Highest bit rate served by each slope setting, in bit/s
    localparam int          SLOPE_LOW_MAX_BPS    = 10400;
    localparam int          SLOPE_NORMAL_MAX_BPS = 20000;

    typedef enum logic [1:0] {
        PRESC_X1_0 = 2'h0,
        PRESC_X1_5 = 2'h1,
        PRESC_X2_5 = 2'h2,
        PRESC_X3_5 = 2'h3
    } lps_presc_type;

    // Reset values
    localparam logic        LIN_ACTIVE_RST  = 1'h0;
    localparam logic        SLOPE_RST       = 1'h0;
    localparam logic        DRIVER_RST      = 1'h0;
    localparam logic        TX_DISABLE_RST  = 1'h0;
    localparam logic        SW_DEV_RST      = 1'h0;

    // Serial frame timing
    localparam logic [4:0]  FRAME_BITS      = 5'h10;
    localparam logic [4:0]  FB_LOAD_BITS    = 5'h03;
    localparam logic [4:0]  BIT_CNT_MAX     = 5'h1f;
    localparam int          SCLK_HALF_DEF   = 4;
endpackage

// [hw/lps_spi_if.sv]
// Serial link between the controller and the register bank
`timescale 1ns/10ps
interface lps_spi_if;
    logic scs_n;
    logic sclk;
    logic mosi;
    logic miso;

    modport device (
        input  scs_n,
        input  sclk,
        input  mosi,
        output miso
    );

    modport host (
        output scs_n,
        output sclk,
        output mosi,
        input  miso
    );
endinterface

// [hw/lps_device.sv]
// Transceiver configuration and special mode register bank, device end
`timescale 1ns/10ps
module lps_device (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    lps_spi_if.device                  spi,
    input  wire logic                  normal_or_flash_mode,
    input  wire logic                  iface_fault_detect,
    input  wire logic                  clean_traffic_seen,
    input  wire lps_pkg::lps_fb_type   gp1_feedback,
    input  wire lps_pkg::lps_fb_type   int_enable_feedback,
    output logic                       bus_active_enable,
    output logic                       bus_slope_select,
    output logic                       bus_driver_strength,
    output logic                       transmitter_disable,
    output logic                       lin_active,
    output logic                       transmitter_on,
    output logic                       iface_fault,
    output logic                       sw_development_init,
    output lps_pkg::lps_presc_type     watchdog_prescale_sel
);
    import lps_pkg::*;

    typedef struct packed {
        logic                  sclk_q;
        logic                  cs_q;
        logic [4:0]            bit_cnt;
        lps_word_type          shift_in;
        logic [FB_W:0]         shift_out;
        logic                  miso;
        logic                  active_en;
        logic                  slope_low;
        logic                  driver_strong;
        logic                  tx_disable;
        logic                  fault;
        logic                  lin_active;
        logic                  tx_on;
        logic                  sw_dev;
        lps_presc_type         presc;
    } lps_dev_state_type;

    lps_dev_state_type state;
    lps_dev_state_type next_state;

    function automatic lps_fb_type lin_cfg_fb(input lps_dev_state_type s);
        lps_fb_type fb;
        fb                 = '0;
        fb[BUS_ACTIVE_BIT] = s.active_en;
        fb[SLOPE_BIT]      = s.slope_low;
        fb[DRIVER_BIT]     = s.driver_strong;
        fb[TX_DISABLE_BIT] = s.tx_disable;
        return fb;
    endfunction

    function automatic lps_fb_type special_fb(input lps_dev_state_type s);
        lps_fb_type fb;
        fb                            = '0;
        fb[SW_DEV_BIT]                = s.sw_dev;
        fb[PRESC_HI_BIT:PRESC_LO_BIT] = s.presc;
        return fb;
    endfunction

    // Feedback chosen once select and choice bits are in
    function automatic lps_fb_type pick_fb(
        input logic [1:0]        sel,
        input logic              choice,
        input lps_dev_state_type s,
        input lps_fb_type        gp1,
        input lps_fb_type        irq
    );
        lps_fb_type fb;
        fb = '0;
        case (sel)
            SEL_LIN_CFG: fb = choice ? gp1 : lin_cfg_fb(s);
            SEL_SPECIAL: fb = choice ? special_fb(s) : irq;
            default:     fb = '0;
        endcase
        return fb;
    endfunction

    logic       rise;
    logic       fall;
    logic       frame_start;
    logic       frame_end;
    logic [1:0] cmd_sel;
    logic       store;

    always_comb
    begin
        next_state  = state;
        rise        = spi.sclk & ~state.sclk_q & ~spi.scs_n;
        fall        = ~spi.sclk & state.sclk_q & ~spi.scs_n;
        frame_start = state.cs_q & ~spi.scs_n;
        frame_end   = ~state.cs_q & spi.scs_n;
        cmd_sel     = state.shift_in[SEL_HI_BIT:SEL_LO_BIT];
        // A short or long frame is dropped whole
        store       = frame_end & (state.bit_cnt == FRAME_BITS)
                      & ~state.shift_in[NO_STORE_BIT];

        next_state.sclk_q = spi.sclk;
        next_state.cs_q   = spi.scs_n;

        if (frame_start)
        begin
            next_state.bit_cnt   = '0;
            next_state.shift_out = '0;
            next_state.miso      = 1'b0;
        end
        else
        begin
            if (rise)
            begin
                next_state.shift_in = {state.shift_in[WORD_W-2:0], spi.mosi};
                if (state.bit_cnt != BIT_CNT_MAX)
                begin
                    next_state.bit_cnt = state.bit_cnt + 5'h01;
                end
                // Third bit completes select and choice, so the answer
                // can start with the read-only bit position
                if (state.bit_cnt == FB_LOAD_BITS - 5'h01)
                begin
                    next_state.shift_out = {1'b0,
                        pick_fb(state.shift_in[1:0], spi.mosi, state,
                                gp1_feedback, int_enable_feedback)};
                end
            end
            if (fall)
            begin
                next_state.miso      = state.shift_out[FB_W];
                next_state.shift_out = {state.shift_out[FB_W-1:0], 1'b0};
            end
        end

        if (frame_end)
        begin
            next_state.miso = 1'b0;
        end

        if (store && cmd_sel == SEL_LIN_CFG)
        begin
            // Reserved positions are not stored, so they read as zero
            next_state.active_en     = state.shift_in[BUS_ACTIVE_BIT];
            next_state.slope_low     = state.shift_in[SLOPE_BIT];
            next_state.driver_strong = state.shift_in[DRIVER_BIT];
            next_state.tx_disable    = state.shift_in[TX_DISABLE_BIT];
            // Disable bit going from one to zero ends a fault
            if (state.tx_disable && !state.shift_in[TX_DISABLE_BIT])
            begin
                next_state.fault = 1'b0;
            end
        end
        if (store && cmd_sel == SEL_SPECIAL)
        begin
            next_state.sw_dev = state.shift_in[SW_DEV_BIT];
            next_state.presc  = lps_presc_type'(
                state.shift_in[PRESC_HI_BIT:PRESC_LO_BIT]);
        end

        // Fault recovery never touches the disable bit; set beats clear
        if (clean_traffic_seen)
        begin
            next_state.fault = 1'b0;
        end
        if (iface_fault_detect)
        begin
            next_state.fault = 1'b1;
        end

        next_state.lin_active = next_state.active_en
                                & normal_or_flash_mode;
        next_state.tx_on      = ~next_state.tx_disable
                                & ~next_state.fault;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state               <= '0;
            state.sclk_q        <= 1'b0;
            state.cs_q          <= 1'b1;
            state.active_en     <= LIN_ACTIVE_RST;
            state.slope_low     <= SLOPE_RST;
            state.driver_strong <= DRIVER_RST;
            state.tx_disable    <= TX_DISABLE_RST;
            state.sw_dev        <= SW_DEV_RST;
            state.presc         <= PRESC_X1_0;
            state.lin_active    <= 1'b0;
            state.tx_on         <= ~TX_DISABLE_RST;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign spi.miso              = state.miso;
    assign bus_active_enable     = state.active_en;
    assign bus_slope_select      = state.slope_low;
    assign bus_driver_strength   = state.driver_strong;
    assign transmitter_disable   = state.tx_disable;
    assign lin_active            = state.lin_active;
    assign transmitter_on        = state.tx_on;
    assign iface_fault           = state.fault;
    assign sw_development_init   = state.sw_dev;
    assign watchdog_prescale_sel = state.presc;
endmodule // lps_device

// [hw/lps_host.sv]
// Controller end: sends one command word per request over the serial link
`timescale 1ns/10ps
module lps_host #(
    parameter int SCLK_HALF = lps_pkg::SCLK_HALF_DEF
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    lps_spi_if.host                    spi,
    input  wire logic                  cmd_valid,
    input  wire lps_pkg::lps_word_type cmd_word,
    output logic                       cmd_ready,
    output logic                       resp_valid,
    output lps_pkg::lps_word_type      resp_word
);
    import lps_pkg::*;

    // Device needs two cycles to see an edge and answer it
    if (SCLK_HALF < 2 || SCLK_HALF > 255)
    begin : g_half_check
        $error("lps_host: SCLK_HALF must be 2..255");
    end

    typedef enum logic [1:0] {
        HST_IDLE  = 2'b00,
        HST_LEAD  = 2'b01,
        HST_SHIFT = 2'b10,
        HST_TRAIL = 2'b11
    } lps_hst_fsm_type;

    typedef struct packed {
        lps_hst_fsm_type fsm;
        logic [7:0]      div;
        logic [4:0]      bits;
        lps_word_type    tx;
        lps_word_type    rx;
        logic            scs_n;
        logic            sclk;
        logic            mosi;
        logic            ready;
        logic            done;
        lps_word_type    resp;
    } lps_host_state_type;

    lps_host_state_type state;
    lps_host_state_type next_state;
    logic               tick;

    always_comb
    begin
        next_state      = state;
        next_state.done = 1'b0;
        tick            = (state.div == 8'(SCLK_HALF - 1));
        if (state.fsm != HST_IDLE)
        begin
            next_state.div = tick ? 8'h00 : state.div + 8'h01;
        end
        case (state.fsm)
            HST_IDLE:
            begin
                if (cmd_valid)
                begin
                    next_state.fsm   = HST_LEAD;
                    next_state.tx    = cmd_word;
                    next_state.scs_n = 1'b0;
                    next_state.mosi  = cmd_word[SEL_HI_BIT];
                    next_state.ready = 1'b0;
                    next_state.div   = '0;
                    next_state.bits  = '0;
                end
            end
            HST_LEAD:
            begin
                if (tick)
                begin
                    next_state.fsm  = HST_SHIFT;
                    next_state.sclk = 1'b1;
                    next_state.rx   = {state.rx[WORD_W-2:0], spi.miso};
                end
            end
            HST_SHIFT:
            begin
                if (tick && !state.sclk)
                begin
                    next_state.sclk = 1'b1;
                    next_state.rx   = {state.rx[WORD_W-2:0], spi.miso};
                end
                else if (tick)
                begin
                    next_state.sclk = 1'b0;
                    next_state.bits = state.bits + 5'h01;
                    next_state.tx   = {state.tx[WORD_W-2:0], 1'b0};
                    next_state.mosi = state.tx[WORD_W-2];
                    if (state.bits == FRAME_BITS - 5'h01)
                    begin
                        next_state.fsm  = HST_TRAIL;
                        next_state.mosi = 1'b0;
                    end
                end
            end
            HST_TRAIL:
            begin
                if (tick)
                begin
                    next_state.fsm   = HST_IDLE;
                    next_state.scs_n = 1'b1;
                    next_state.ready = 1'b1;
                    next_state.done  = 1'b1;
                    next_state.resp  = state.rx;
                end
            end
            default:
            begin
                next_state = state;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state       <= '0;
            state.fsm   <= HST_IDLE;
            state.scs_n <= 1'b1;
            state.ready <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign spi.scs_n  = state.scs_n;
    assign spi.sclk   = state.sclk;
    assign spi.mosi   = state.mosi;
    assign cmd_ready  = state.ready;
    assign resp_valid = state.done;
    assign resp_word  = state.resp;
endmodule // lps_host

// [test/lps_link_checker.sv]
// Link timing and register output checks for the LIN register bank
`timescale 1ns/10ps
module lps_link_checker #(
    parameter int SCLK_HALF = 2
) (
    input wire logic                   core_clk,
    input wire logic                   rst_n,
    input wire logic                   scs_n,
    input wire logic                   sclk,
    input wire logic                   cmd_valid,
    input wire logic                   cmd_ready,
    input wire logic                   resp_valid,
    input wire logic                   normal_or_flash_mode,
    input wire logic                   iface_fault_detect,
    input wire logic                   bus_active_enable,
    input wire logic                   bus_slope_select,
    input wire logic                   bus_driver_strength,
    input wire logic                   transmitter_disable,
    input wire logic                   lin_active,
    input wire logic                   transmitter_on,
    input wire logic                   iface_fault,
    input wire logic                   sw_development_init,
    input wire lps_pkg::lps_presc_type watchdog_prescale_sel
);
    import lps_pkg::*;
    // Take edge to the first edge that samples the answer pulse
    localparam int RESP_DLY = 33 * SCLK_HALF + 1;
    logic       take;
    logic       gate_on;
    logic       tx_off;
    logic [6:0] stored;
    assign take    = cmd_valid & cmd_ready;
    assign gate_on = bus_active_enable & normal_or_flash_mode;
    assign tx_off  = transmitter_disable | iface_fault;
    assign stored  = {bus_active_enable, bus_slope_select, bus_driver_strength,
                      transmitter_disable, sw_development_init,
                      watchdog_prescale_sel};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_sclk_idle_low: assert property (scs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    // Written for the bench setting of two cycles per half period
    a_sclk_half_width: assert property (
        $rose(sclk) |-> sclk[*2] ##1 !sclk)
        else $error("serial clock half period wrong");
    a_answer_delay: assert property (take |-> ##RESP_DLY resp_valid)
        else $error("answer not at the fixed delay");
    a_busy_no_answer: assert property (
        take |=> (!cmd_ready && !resp_valid)[*8])
        else $error("early answer or ready");
    a_resp_single: assert property (
        resp_valid |=> !resp_valid && cmd_ready)
        else $error("answer pulse too long");
    a_store_in_frame: assert property (
        (!scs_n)[*3] |=> $stable(stored))
        else $error("settings changed inside a frame");
    a_lin_mode_gate: assert property (
        $stable(gate_on) |-> lin_active == gate_on)
        else $error("active operation not gated by mode");
    a_tx_gating: assert property (
        $stable(tx_off) |-> transmitter_on == !tx_off)
        else $error("transmitter state wrong");
    a_fault_latch: assert property (
        iface_fault_detect |=> iface_fault)
        else $error("interface fault not latched");

    cover property (take ##RESP_DLY resp_valid);
    cover property ($rose(iface_fault));
    cover property ($rose(lin_active));
endmodule // lps_link_checker

// [test/lin_phy_and_special_mode_regs_tb.sv]
// Self-checking bench joining host and device ends of the register link
`timescale 1ns/10ps
module lin_phy_and_special_mode_regs_tb;
    import lps_pkg::*;
    localparam int HALF = 2;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    lps_word_type cmd_word = 16'h0000;
    logic cmd_ready;
    logic resp_valid;
    lps_word_type resp_word;
    logic normal_or_flash_mode = 1'b1;
    logic iface_fault_detect = 1'b0;
    logic clean_traffic_seen = 1'b0;
    lps_fb_type gp1_feedback = 12'ha5c;
    lps_fb_type int_enable_feedback = 12'h3c6;
    logic bus_active_enable, bus_slope_select, bus_driver_strength;
    logic transmitter_disable, lin_active, transmitter_on, iface_fault;
    logic sw_development_init;
    lps_presc_type watchdog_prescale_sel;
    lps_word_type view, last_cmd, shreg, frame_word;
    lps_word_type rises = 16'h0000;
    lps_word_type frame_rises = 16'h0000;
    logic sclk_q = 1'b0;
    logic scs_q = 1'b1;
    int mismatches = 0;
    int checks = 0;

    always #10 core_clk = ~core_clk;
    // Packed view of every device output, compared as one word
    assign view = {6'h00, watchdog_prescale_sel, lin_active, transmitter_on,
                   iface_fault, bus_active_enable, bus_slope_select,
                   bus_driver_strength, transmitter_disable,
                   sw_development_init};

    lps_spi_if spi ();
    lps_host #(.SCLK_HALF(HALF)) lps_host_inst (.core_clk(core_clk),
        .rst_n(rst_n), .spi(spi), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_word(resp_word));
    lps_device lps_device_inst (.core_clk(core_clk), .rst_n(rst_n), .spi(spi),
        .normal_or_flash_mode(normal_or_flash_mode),
        .iface_fault_detect(iface_fault_detect),
        .clean_traffic_seen(clean_traffic_seen), .gp1_feedback(gp1_feedback),
        .int_enable_feedback(int_enable_feedback),
        .bus_active_enable(bus_active_enable),
        .bus_slope_select(bus_slope_select),
        .bus_driver_strength(bus_driver_strength),
        .transmitter_disable(transmitter_disable), .lin_active(lin_active),
        .transmitter_on(transmitter_on), .iface_fault(iface_fault),
        .sw_development_init(sw_development_init),
        .watchdog_prescale_sel(watchdog_prescale_sel));
    lps_link_checker #(.SCLK_HALF(HALF)) lps_link_checker_inst (
        .core_clk(core_clk), .rst_n(rst_n), .scs_n(spi.scs_n),
        .sclk(spi.sclk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .normal_or_flash_mode(normal_or_flash_mode),
        .iface_fault_detect(iface_fault_detect),
        .bus_active_enable(bus_active_enable),
        .bus_slope_select(bus_slope_select),
        .bus_driver_strength(bus_driver_strength),
        .transmitter_disable(transmitter_disable), .lin_active(lin_active),
        .transmitter_on(transmitter_on), .iface_fault(iface_fault),
        .sw_development_init(sw_development_init),
        .watchdog_prescale_sel(watchdog_prescale_sel));

    task automatic results;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp(input lps_word_type got, input lps_word_type exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Sampled at the falling edge so the link lines are settled
    always @(negedge core_clk)
    begin
        if (spi.scs_n === 1'b1 && scs_q === 1'b0)
        begin
            frame_rises = rises;
            frame_word = shreg;
            rises = 16'h0000;
        end
        else if (!spi.scs_n && spi.sclk && !sclk_q)
        begin
            shreg = {shreg[14:0], spi.mosi};
            rises = rises + 16'h0001;
        end
        sclk_q = spi.sclk;
        scs_q = spi.scs_n;
    end

    task automatic wait_high(ref logic sig);
        int n;
        n = 0;
        while (sig !== 1'b1)
        begin
            @(negedge core_clk);
            n++;
            if (n > 300)
            begin
                mismatches++;
                results();
            end
        end
    endtask

    // One whole frame; the answer is judged, then the commit is let land
    task automatic xfer(input lps_word_type w, input lps_word_type ans);
        @(negedge core_clk);
        wait_high(cmd_ready);
        cmd_word = w;
        last_cmd = w;
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        wait_high(resp_valid);
        cmp(resp_word, ans);
        repeat (3) @(negedge core_clk);
        // Frame latched by the link monitor at the select release
        cmp(frame_rises, 16'h0010);
        cmp(frame_word, last_cmd);
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge core_clk);
        sig = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    // Stimulus keeps every reserved command bit at zero, except 4018, 0fff and 8fff in t_special
    task automatic t_config;
        xfer(16'hc01d, 16'h0000);
        cmp(view, 16'h009e);
        xfer(16'hd000, 16'h001d);
        xfer(16'hf001, 16'h0a5c);
        cmp(view, 16'h009e);
        normal_or_flash_mode = 1'b0;
        repeat (3) @(negedge core_clk);
        cmp(view, 16'h001e);
        normal_or_flash_mode = 1'b1;
        xfer(16'hc000, 16'h001d);
        xfer(16'hd000, 16'h0000);
        cmp(view, 16'h0040);
    endtask

    task automatic t_special;
        xfer(16'h4260, 16'h03c6);
        cmp(view, 16'h0341);
        xfer(16'h7000, 16'h0260);
        xfer(16'h5000, 16'h03c6);
        cmp(view, 16'h0341);
        xfer(16'h4018, 16'h03c6);
        xfer(16'h7000, 16'h0000);
        for (int c = 0; c < 4; c++)
        begin
            xfer(16'h4000 | lps_word_type'(c << 5), 16'h03c6);
            xfer(16'h7000, lps_word_type'(c << 5));
            cmp(view, 16'h0040 | lps_word_type'(c << 8));
        end
        xfer(16'h0fff, 16'h0000);
        xfer(16'h8fff, 16'h0000);
        cmp(view, 16'h0340);
    endtask

    task automatic t_fault;
        pulse(iface_fault_detect);
        cmp(view, 16'h0320);
        pulse(clean_traffic_seen);
        cmp(view, 16'h0340);
        pulse(iface_fault_detect);
        xfer(16'hc005, 16'h0000);
        cmp(view, 16'h0326);
        xfer(16'hc000, 16'h0005);
        cmp(view, 16'h0340);
    endtask

    initial
    begin
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        cmp(view, 16'h0040);
        t_config();
        t_special();
        t_fault();
        results();
    end
endmodule // lin_phy_and_special_mode_regs_tb
